// [intc_pkg.sv]
// Functional notes
// [R1] No acknowledge unless global gate set
// [R2] Each source needs its own enable bit
// [R3] Vectors ext0 0003, tmr0 000B, ext1 0013
// [R4] Tmr1 001B; serial rx or tx 0023
// [R5] Software keeps port latch high for pins
// [R6] Edge select 0: low level requests
// [R7] Edge select 1: falling edge requests
// [R8] Level bit 1 means high priority
// [R9] Same or lower level never preempts
// [R10] Fixed order ext0 tmr0 ext1 tmr1 serial
// [R11] Order only for simultaneous requests
// [R12] Software writes no ones to reserved bits
// [R13] Timer flags set on overflow, cleared on vector
// [R14] One in-service marker per level
// [R15] Enable and level bit layout
package intc_pkg;
  localparam logic [1:0] ADDR_ENABLE = 2'h0;
  localparam logic [1:0] ADDR_LEVEL  = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_MASK   = 2'h3;
  localparam int GATE_BIT = 7;
  localparam int NSRC     = 5;
  localparam logic [7:0] ENABLE_WMASK = 8'h9F;
  localparam logic [7:0] LEVEL_WMASK  = 8'h1F;
  localparam logic [7:0] ENABLE_RST   = 8'h00;
  localparam logic [7:0] LEVEL_RST    = 8'h00;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TMR0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TMR1 = 16'h001B;
  localparam logic [15:0] VEC_SER  = 16'h0023;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER  = 4;
endpackage

// [ext_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module ext_detect (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic edge_sel,
  input  wire logic clr,
  output logic      flag
);
  logic prev_r;
  logic flag_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= pin;
    end
  end
  // Edge mode latches until vectored; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (edge_sel && prev_r && !pin) begin
      flag_r <= 1'b1; // see [R7]
    end else if (clr || !edge_sel) begin
      flag_r <= 1'b0;
    end
  end
  assign flag = edge_sel ? flag_r : !pin; // see [R6]
endmodule
`default_nettype wire

// [intc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module intc_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        ext0_pin,
  input  wire logic        ext1_pin,
  input  wire logic        ext0_edge_sel,
  input  wire logic        ext1_edge_sel,
  input  wire logic        tmr0_ovf,
  input  wire logic        tmr1_ovf,
  input  wire logic        rx_done_flag,
  input  wire logic        tx_done_flag,
  input  wire logic        ack,
  input  wire logic        reti,
  output logic             irq_req,
  output logic      [15:0] vector,
  output logic             tmr0_ovf_flag,
  output logic             tmr1_ovf_flag,
  output logic             ext0_flag,
  output logic             ext1_flag,
  output logic             irq
);
  logic [7:0]  enable_mask_reg_r;
  logic [7:0]  level_sel_reg_r;
  logic [4:0]  status_r;
  logic [4:0]  mask_r;
  logic [7:0]  rdata_r;
  logic        tmr0_r;
  logic        tmr1_r;
  logic [1:0]  in_service_r;
  logic [15:0] vector_r;
  logic [4:0]  pending;
  logic [4:0]  eligible;
  logic [4:0]  hi_req;
  logic [4:0]  lo_req;
  logic [4:0]  pick;
  logic        pick_hi;
  logic [4:0]  take;
  logic [4:0]  status_set;

  function automatic logic [4:0] first_one(input logic [4:0] v);
    first_one = v & (~v + 5'h01);
  endfunction

  function automatic logic [15:0] vec_of(input logic [4:0] p);
    unique case (1'b1)
      p[intc_pkg::SRC_EXT0]: vec_of = intc_pkg::VEC_EXT0;
      p[intc_pkg::SRC_TMR0]: vec_of = intc_pkg::VEC_TMR0;
      p[intc_pkg::SRC_EXT1]: vec_of = intc_pkg::VEC_EXT1;
      p[intc_pkg::SRC_TMR1]: vec_of = intc_pkg::VEC_TMR1;
      default:               vec_of = intc_pkg::VEC_SER;
    endcase
  endfunction

  assign take = ack ? pick : 5'h00;

  ext_detect u_ext0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin      (ext0_pin),
    .edge_sel (ext0_edge_sel),
    .clr      (take[intc_pkg::SRC_EXT0]),
    .flag     (ext0_flag)
  );
  ext_detect u_ext1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin      (ext1_pin),
    .edge_sel (ext1_edge_sel),
    .clr      (take[intc_pkg::SRC_EXT1]),
    .flag     (ext1_flag)
  );

  // Timer flags: overflow sets, vectoring clears, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr0_r <= 1'b0;
      tmr1_r <= 1'b0;
    end else begin
      tmr0_r <= tmr0_ovf | (tmr0_r & ~take[intc_pkg::SRC_TMR0]); // see [R13]
      tmr1_r <= tmr1_ovf | (tmr1_r & ~take[intc_pkg::SRC_TMR1]); // see [R13]
    end
  end
  assign tmr0_ovf_flag = tmr0_r;
  assign tmr1_ovf_flag = tmr1_r;

  assign pending = {rx_done_flag | tx_done_flag, tmr1_r, ext1_flag, tmr0_r, ext0_flag}; // see [R4]
  assign eligible = enable_mask_reg_r[intc_pkg::GATE_BIT]
                    ? (pending & enable_mask_reg_r[4:0]) : 5'h00; // see [R1] see [R2]
  assign hi_req = eligible & level_sel_reg_r[4:0];  // see [R8]
  assign lo_req = eligible & ~level_sel_reg_r[4:0];

  // High level blocked only by high in service; low by either
  always_comb begin
    pick    = 5'h00;
    pick_hi = 1'b0;
    if (!in_service_r[1] && hi_req != 5'h00) begin // see [R9]
      pick    = first_one(hi_req); // see [R10]
      pick_hi = 1'b1;
    end else if (in_service_r == 2'b00 && lo_req != 5'h00) begin // see [R11]
      pick = first_one(lo_req); // see [R10]
    end
  end
  assign irq_req = pick != 5'h00;
  assign vector  = vec_of(pick); // see [R3] see [R4]

  // Markers: set on ack, reti clears the highest active level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_service_r <= 2'b00;
    end else if (ack && irq_req) begin
      in_service_r[pick_hi ? 1 : 0] <= 1'b1; // see [R14]
    end else if (reti) begin
      if (in_service_r[1]) begin
        in_service_r[1] <= 1'b0; // see [R14]
      end else begin
        in_service_r[0] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_r <= 16'h0000;
    end else if (ack && irq_req) begin
      vector_r <= vector;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_mask_reg_r <= intc_pkg::ENABLE_RST;
      level_sel_reg_r   <= intc_pkg::LEVEL_RST;
      mask_r            <= 5'h00;
    end else if (wr) begin
      unique case (addr)
        intc_pkg::ADDR_ENABLE: enable_mask_reg_r <= wdata & intc_pkg::ENABLE_WMASK; // see [R15]
        intc_pkg::ADDR_LEVEL:  level_sel_reg_r <= wdata & intc_pkg::LEVEL_WMASK; // see [R15]
        intc_pkg::ADDR_MASK:   mask_r <= wdata[4:0];
        default: ;
      endcase
    end
  end

  // Status records accepted sources; write one clears, set wins
  assign status_set = take;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 5'h00;
    end else if (wr && addr == intc_pkg::ADDR_STATUS) begin
      status_r <= (status_r & ~wdata[4:0]) | status_set;
    end else begin
      status_r <= status_r | status_set;
    end
  end
  assign irq = (status_r & mask_r) != 5'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        intc_pkg::ADDR_ENABLE: rdata_r <= enable_mask_reg_r;
        intc_pkg::ADDR_LEVEL:  rdata_r <= level_sel_reg_r;
        intc_pkg::ADDR_STATUS: rdata_r <= {3'h0, status_r};
        default:               rdata_r <= {3'h0, mask_r};
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;

  a_gate_off_no_req: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_mask_reg_r[intc_pkg::GATE_BIT] |-> !irq_req) // see [R1]
    else $error("request with gate off");
  a_src_enable_needed: assert property (@(posedge clk) disable iff (!rst_n)
    (pick & ~enable_mask_reg_r[4:0]) == 5'h00) // see [R2]
    else $error("disabled source picked");
  a_vec_ext0: assert property (@(posedge clk) disable iff (!rst_n)
    pick[intc_pkg::SRC_EXT0] |-> vector == 16'h0003) // see [R3]
    else $error("wrong ext0 vector");
  a_vec_serial: assert property (@(posedge clk) disable iff (!rst_n)
    pick[intc_pkg::SRC_SER] |-> vector == 16'h0023) // see [R4]
    else $error("wrong serial vector");
  a_level_mode: assert property (@(posedge clk) disable iff (!rst_n)
    !ext0_edge_sel |-> ext0_flag == !ext0_pin) // see [R6]
    else $error("level mode mismatch");
  a_fall_edge: assert property (@(posedge clk) disable iff (!rst_n)
    ext0_edge_sel && $past(ext0_edge_sel) && $fell(ext0_pin) |-> ##1 ext0_flag) // see [R7]
    else $error("falling edge missed");
  a_hi_first: assert property (@(posedge clk) disable iff (!rst_n)
    hi_req != 5'h00 && !in_service_r[1] |-> pick_hi) // see [R8]
    else $error("high level not preferred");
  a_no_preempt: assert property (@(posedge clk) disable iff (!rst_n)
    in_service_r[1] |-> !irq_req) // see [R9]
    else $error("preempt of high service");
  a_fixed_order: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req |-> $onehot(pick) && ((pick - 5'h01) & (pick_hi ? hi_req : lo_req)) == 5'h00) // see [R10]
    else $error("order violated");
  a_tmr_clear: assert property (@(posedge clk) disable iff (!rst_n)
    take[intc_pkg::SRC_TMR0] && !tmr0_ovf |=> !tmr0_ovf_flag) // see [R13]
    else $error("timer flag not cleared");
  a_marker_set: assert property (@(posedge clk) disable iff (!rst_n)
    ack && pick_hi |=> in_service_r[1]) // see [R14]
    else $error("marker not set");
  a_gate_blocks_all: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_mask_reg_r[intc_pkg::GATE_BIT] |-> eligible == 5'h00) // see [R1]
    else $error("eligible source with gate off");
  a_vec_tmr0: assert property (@(posedge clk) disable iff (!rst_n)
    pick[intc_pkg::SRC_TMR0] |-> vector == intc_pkg::VEC_TMR0) // see [R3]
    else $error("wrong tmr0 vector");
  a_vec_ext1: assert property (@(posedge clk) disable iff (!rst_n)
    pick[intc_pkg::SRC_EXT1] |-> vector == intc_pkg::VEC_EXT1) // see [R3]
    else $error("wrong ext1 vector");
  a_vec_tmr1: assert property (@(posedge clk) disable iff (!rst_n)
    pick[intc_pkg::SRC_TMR1] |-> vector == intc_pkg::VEC_TMR1) // see [R4]
    else $error("wrong tmr1 vector");
  a_ser_shared: assert property (@(posedge clk) disable iff (!rst_n)
    pick[intc_pkg::SRC_SER] |-> (rx_done_flag || tx_done_flag)) // see [R4]
    else $error("serial picked without flag");
  a_level_mode1: assert property (@(posedge clk) disable iff (!rst_n)
    !ext1_edge_sel |-> ext1_flag == !ext1_pin) // see [R6]
    else $error("ext1 level mode mismatch");
  a_fall_edge1: assert property (@(posedge clk) disable iff (!rst_n)
    ext1_edge_sel && $past(ext1_edge_sel) && $fell(ext1_pin) |-> ##1 ext1_flag) // see [R7]
    else $error("ext1 falling edge missed");
  a_lo_behind_hi: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req && !pick_hi |-> hi_req == 5'h00) // see [R8]
    else $error("low picked over high");
  a_nest_allowed: assert property (@(posedge clk) disable iff (!rst_n)
    in_service_r == 2'b01 && hi_req != 5'h00 |-> irq_req && pick_hi) // see [R9]
    else $error("high request not nested");
  a_low_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    in_service_r[0] && !pick_hi |-> !irq_req) // see [R11]
    else $error("same level preempted");
  a_lo_when_idle: assert property (@(posedge clk) disable iff (!rst_n)
    in_service_r == 2'b00 && hi_req == 5'h00 && lo_req != 5'h00 |-> irq_req && !pick_hi) // see [R10]
    else $error("idle low request not offered");
  a_tmr0_set: assert property (@(posedge clk) disable iff (!rst_n)
    tmr0_ovf |=> tmr0_ovf_flag) // see [R13]
    else $error("tmr0 flag not set");
  a_tmr1_set: assert property (@(posedge clk) disable iff (!rst_n)
    tmr1_ovf |=> tmr1_ovf_flag) // see [R13]
    else $error("tmr1 flag not set");
  a_tmr1_clear: assert property (@(posedge clk) disable iff (!rst_n)
    take[intc_pkg::SRC_TMR1] && !tmr1_ovf |=> !tmr1_ovf_flag) // see [R13]
    else $error("tmr1 flag not cleared");
  a_marker_lo: assert property (@(posedge clk) disable iff (!rst_n)
    ack && irq_req && !pick_hi |=> in_service_r[0]) // see [R14]
    else $error("low marker not set");
  a_reti_clear_hi: assert property (@(posedge clk) disable iff (!rst_n)
    reti && !ack && in_service_r[1] |=> !in_service_r[1]) // see [R14]
    else $error("high marker not cleared");
  a_enable_layout: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == intc_pkg::ADDR_ENABLE |=>
      enable_mask_reg_r == $past(wdata & intc_pkg::ENABLE_WMASK)) // see [R15]
    else $error("enable write wrong");
  a_level_layout: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == intc_pkg::ADDR_LEVEL |=>
      level_sel_reg_r == $past(wdata & intc_pkg::LEVEL_WMASK)) // see [R15]
    else $error("level write wrong");
  a_vector_held: assert property (@(posedge clk) disable iff (!rst_n)
    ack && irq_req |=> vector_r == $past(vector))
    else $error("accepted vector not held");
  a_status_set: assert property (@(posedge clk) disable iff (!rst_n)
    take != 5'h00 |=> (status_r & $past(take)) == $past(take))
    else $error("status not set on accept");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00)
    else $error("read data without read");
  c_low_taken: cover property (@(posedge clk) disable iff (!rst_n) ack && irq_req && !pick_hi);
  c_edge_ext: cover property (@(posedge clk) disable iff (!rst_n)
    ext0_edge_sel && ack && pick[intc_pkg::SRC_EXT0]);
  c_nested: cover property (@(posedge clk) disable iff (!rst_n)
    in_service_r[0] && ack && pick_hi);
  c_serial: cover property (@(posedge clk) disable iff (!rst_n) ack && pick[intc_pkg::SRC_SER]);
endmodule
`default_nettype wire

// [core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic irq_req,
  input  wire logic allow,
  output logic      ack
);
  // Takes a request a cycle after it shows, never on two cycles in a row
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= irq_req & allow & ~ack;
    end
  end
endmodule
`default_nettype wire

// [two_level_vectored_interrupt_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module two_level_vectored_interrupt_tb;
  localparam logic [1:0] en_a = intc_pkg::ADDR_ENABLE;
  localparam logic [1:0] lv_a = intc_pkg::ADDR_LEVEL;
  localparam logic [1:0] st_a = intc_pkg::ADDR_STATUS;
  localparam logic [15:0] vt [6] = '{intc_pkg::VEC_EXT0, intc_pkg::VEC_TMR0,
    intc_pkg::VEC_EXT1, intc_pkg::VEC_TMR1, intc_pkg::VEC_SER, intc_pkg::VEC_SER};
  logic        clk, rst_n, wr, rd, ack, allow, irq_req, irq, rd_q;
  logic        ext0_pin, ext1_pin, ext0_edge_sel, ext1_edge_sel, rx_done_flag, tx_done_flag;
  logic        tmr0_ovf_flag, tmr1_ovf_flag, ext0_flag, ext1_flag;
  logic [1:0]  addr;
  logic [2:0]  ev;
  logic [7:0]  wdata, rdata, r;
  logic [15:0] vector;
  logic [15:0] vq[$];
  logic [7:0]  rq[$];
  int          num_errors, checks_done;

  intc_top intc_top_inst (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ext0_pin, .ext1_pin,
    .ext0_edge_sel, .ext1_edge_sel, .tmr0_ovf(ev[0]), .tmr1_ovf(ev[1]), .rx_done_flag,
    .tx_done_flag, .ack, .reti(ev[2]), .irq_req, .vector, .tmr0_ovf_flag, .tmr1_ovf_flag,
    .ext0_flag, .ext1_flag, .irq);
  core_model core_model_inst (.clk, .rst_n, .irq_req, .allow, .ack);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_ack;
    for (int n = 0; n < 60; n++) begin
      @(posedge clk);
      if ((ack & irq_req) === 1'b1) return;
    end
    num_errors++;
    end_sim;
  endtask
  task automatic quiet;
    repeat (4) @(posedge clk);
    cmp("irq_req", 16'h0000, 16'(irq_req));
  endtask
  task automatic serve(input int s);
    vq.push_back(vt[s]);
    case (s)
      0: ext0_pin <= 1'b0;
      2: ext1_pin <= 1'b0;
      4: rx_done_flag <= 1'b1;
      5: tx_done_flag <= 1'b1;
      default: pulse(s == 1 ? 0 : 1);
    endcase
    wait_ack;
    {ext0_pin, ext1_pin, rx_done_flag, tx_done_flag} <= 4'b1100;
    @(posedge clk);
    pulse(2);
  endtask

  // Every acceptance and every read answer is matched against the oldest note
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q === 1'b1) cmp("rdata", {8'h00, rq.pop_front()}, {8'h00, rdata});
    if ((ack & irq_req) === 1'b1) cmp("vector", vq.size() ? vq.pop_front() : 16'hFFFF, vector);
  end

  initial begin
    {rst_n, wr, rd, allow, ext0_edge_sel, ext1_edge_sel, rx_done_flag, tx_done_flag} = '0;
    {ext0_pin, ext1_pin} = 2'b11;
    {addr, wdata, ev, r} = '0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(26949));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    allow <= 1'b1;
    for (int a = 0; a < 4; a++) rreg(2'(a), 8'h00);
    r = 8'($urandom());
    wreg(en_a, r & intc_pkg::ENABLE_WMASK);
    wreg(lv_a, r & intc_pkg::LEVEL_WMASK);
    rreg(en_a, r & intc_pkg::ENABLE_WMASK);
    rreg(lv_a, r & intc_pkg::LEVEL_WMASK);
    wreg(lv_a, 8'h00);
    $display("registers done");
    wreg(en_a, 8'h9F);
    ext1_edge_sel <= 1'b1;
    for (int s = 0; s < 6; s++) serve(s);
    rreg(st_a, 8'h1F);
    wreg(intc_pkg::ADDR_MASK, 8'h04);
    cmp("irq", 16'h0001, 16'(irq));
    wreg(st_a, 8'h04);
    cmp("irq", 16'h0000, 16'(irq));
    rreg(st_a, 8'h1B);
    $display("vectors done");
    wreg(en_a, 8'h1F);
    pulse(0);
    quiet;
    wreg(en_a, 8'h95);
    pulse(1);
    quiet;
    cmp("tmr1_ovf_flag", 16'h0001, 16'(tmr1_ovf_flag));
    vq.push_back(vt[1]);
    vq.push_back(vt[3]);
    wreg(en_a, 8'h9F);
    wait_ack;
    @(posedge clk);
    cmp("tmr0_ovf_flag", 16'h0000, 16'(tmr0_ovf_flag));
    pulse(2);
    wait_ack;
    pulse(2);
    $display("gating done");
    wreg(lv_a, 8'h08);
    vq.push_back(vt[1]);
    pulse(0);
    wait_ack;
    pulse(0);
    quiet;
    vq.push_back(vt[3]);
    pulse(1);
    wait_ack;
    pulse(2);
    quiet;
    vq.push_back(vt[1]);
    pulse(2);
    wait_ack;
    pulse(2);
    wreg(lv_a, 8'h00);
    $display("nesting done");
    allow <= 1'b0;
    ext0_edge_sel <= 1'b1;
    @(posedge clk);
    {ext0_pin, ext1_pin, rx_done_flag, ev} <= 6'b001011;
    @(posedge clk);
    ev <= 3'b000;
    allow <= 1'b1;
    for (int s = 0; s < 5; s++) vq.push_back(vt[s]);
    @(posedge clk);
    cmp("ext0_flag", 16'h0001, 16'(ext0_flag));
    cmp("ext1_flag", 16'h0001, 16'(ext1_flag));
    for (int s = 0; s < 5; s++) begin
      wait_ack;
      if (s == 4) rx_done_flag <= 1'b0;
      @(posedge clk);
      pulse(2);
    end
    {ext0_pin, ext1_pin} <= 2'b11;
    cmp("pending", 16'h0000, 16'(vq.size()));
    $display("order done");
    end_sim;
  end
endmodule
`default_nettype wire
